// [rtl/rtc_serial_pin_interface.sv]
// Pin-level real-time clock: serial link, reference output, interrupts and user RAM.
`timescale 1ns/10ps
// Contract
// R1 - Access only while both enables high
// R2 - Deselected: output released, clock and data ignored
// R3 - Write mode samples data on rising edge
// R4 - Read mode updates output on falling edge
// R5 - Reference output driven only while enabled
// R6 - Continuous 32.768 kHz push-pull reference clock
// R7 - Timer interrupt on open-drain pin
// R8 - Alarm and update share second open-drain pin
// R9 - Alarm on weekday, day, hour, minute match
// R10 - Update interrupt every second or minute
// R11 - Automatic leap days, years 2000 to 2099
// R12 - Sixteen byte user memory over link
// R13 - Host may join data lines, avoiding contention
// R14 - Interrupt held low until flag cleared
// R15 - Deselect ends transfer, resets shift logic
module rtc_serial_pin_interface #(
   parameter int SEC_CYCLES = rtc_pkg::SYS_HZ
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic chip_enable_a,
   input  wire logic chip_enable_b,
   input  wire logic serial_clk,
   input  wire logic serial_data_in,
   output      logic serial_data_out,
   output      logic serial_data_out_oe,
   input  wire logic refclk_out_enable,
   output      logic refclk_out,
   output      logic refclk_out_oe,
   output      logic timer_irq_n,
   output      logic timer_irq_n_oe,
   output      logic alarm_irq_n,
   output      logic alarm_irq_n_oe
);
   import rtc_pkg::*;

   localparam int SEC_W = $clog2(SEC_CYCLES);
   if (SEC_CYCLES < 2) begin : g_bad_sec
      $error("SEC_CYCLES must be at least 2");
   end
   logic                 sel, rise, fall, byte_done, wr_en, cal_we, tmr_load;
   logic                 minute_tick, alarm_match, alarm_set, upd_set, tmr_set;
   logic [BYTE_W-1:0]    in_byte, rd_byte;
   reg_write_type        wr;
   cal_time_type         now;
   logic [FLAG_W-1:0]    flag_clr, flag_set, flags_ff;
   logic [NCO_W:0]       nco_sum;
   logic [SEC_W-1:0]     sec_cnt_ff;
   logic [NCO_W-1:0]     nco_ff;
   logic [GAP_W-1:0]     ref_gap_ff;
   logic                 sec_tick_ff, refclk_ff, refclk_oe_ff, sclk_prev_ff, sdo_ff, sdo_oe_ff;
   logic                 timer_irq_n_n_ff, timer_irq_n_oe_ff, alarm_irq_n_n_ff, alarm_irq_n_oe_ff;
   phase_type            phase_ff;
   logic [BIT_CNT_W-1:0] bit_cnt_ff;
   logic [BYTE_W-1:0]    shift_ff, out_sr_ff, alm_min_ff, alm_hour_ff, alm_day_ff, alm_week_ff;
   logic [BYTE_W-1:0]    tmr_reload_ff, tmr_cnt_ff, ctrl_ff;
   logic [ADDR_W-1:0]    addr_ff;
   logic [BYTE_W-1:0]    ram_ff [RAM_DEPTH];

   // One-second time base from the system clock.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sec_cnt_ff  <= '0;
         sec_tick_ff <= 1'b0;
      end else if (ce) begin
         sec_tick_ff <= (sec_cnt_ff == SEC_W'(SEC_CYCLES - 1));
         sec_cnt_ff  <= (sec_cnt_ff == SEC_W'(SEC_CYCLES - 1)) ? '0 : sec_cnt_ff + 1'b1;
      end
   end

   // A phase accumulator gives the reference clock; the period jitters by one
   // system cycle because 10 MHz is no integer multiple of the reference.
   assign nco_sum = {1'b0, nco_ff} + {1'b0, NCO_INC};

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         nco_ff       <= '0;
         refclk_ff    <= 1'b0;
         refclk_oe_ff <= 1'b0;
         ref_gap_ff   <= '0;
      end else if (ce) begin
         nco_ff       <= nco_sum[NCO_W-1:0];
         refclk_oe_ff <= refclk_out_enable; // [R5]
         if (nco_sum[NCO_W]) begin
            refclk_ff  <= ~refclk_ff; // [R6]
            ref_gap_ff <= '0;
         end else begin
            ref_gap_ff <= ref_gap_ff + 1'b1;
         end
      end
   end

   // Serial link front end.
   assign sel       = chip_enable_a & chip_enable_b; // [R1]
   assign rise      = sel & serial_clk & ~sclk_prev_ff; // [R2] [R3]
   assign fall      = sel & ~serial_clk & sclk_prev_ff; // [R2] [R4]
   assign byte_done = rise && (bit_cnt_ff == LAST_BIT);
   assign in_byte   = {shift_ff[BYTE_W-2:0], serial_data_in};
   assign wr_en     = byte_done && (phase_ff == PH_WR);
   assign wr        = '{idx: addr_ff, data: in_byte};
   assign cal_we    = wr_en && !addr_ff[RAM_SEL_BIT] && (addr_ff <= REG_YEAR);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sclk_prev_ff <= 1'b0;
      end else if (ce) begin
         sclk_prev_ff <= serial_clk;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         phase_ff   <= PH_CMD;
         bit_cnt_ff <= FIRST_BIT;
         shift_ff   <= '0;
         addr_ff    <= '0;
      end else if (ce) begin
         if (!sel) begin
            phase_ff   <= PH_CMD; // [R15]
            bit_cnt_ff <= FIRST_BIT; // [R15]
         end else if (rise) begin
            shift_ff   <= in_byte; // [R3]
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
            if (bit_cnt_ff == LAST_BIT) begin
               case (phase_ff)
                  PH_CMD: begin
                     phase_ff <= in_byte[CMD_RD_BIT] ? PH_RD : PH_WR;
                     addr_ff  <= in_byte[ADDR_W-1:0];
                  end
                  default: addr_ff <= addr_ff + 1'b1;
               endcase
            end
         end
      end
   end

   // Read data: the first bit of each byte leaves on the falling edge that
   // follows the byte boundary, so the host samples it on the next rise.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sdo_ff    <= 1'b0;
         sdo_oe_ff <= 1'b0;
         out_sr_ff <= '0;
      end else if (ce) begin
         if (!sel) begin
            sdo_oe_ff <= 1'b0; // [R2]
         end else if (fall && phase_ff == PH_RD) begin
            sdo_oe_ff <= 1'b1;
            if (bit_cnt_ff == FIRST_BIT) begin
               sdo_ff    <= rd_byte[BYTE_W-1]; // [R4]
               out_sr_ff <= {rd_byte[BYTE_W-2:0], 1'b0};
            end else begin
               sdo_ff    <= out_sr_ff[BYTE_W-1]; // [R4]
               out_sr_ff <= {out_sr_ff[BYTE_W-2:0], 1'b0};
            end
         end
      end
   end

   always_comb begin
      rd_byte = '0;
      if (addr_ff[RAM_SEL_BIT]) begin
         rd_byte = ram_ff[addr_ff[RAM_AW-1:0]]; // [R12]
      end else begin
         case (addr_ff)
            REG_SEC:      rd_byte = now.sec;
            REG_MIN:      rd_byte = now.min;
            REG_HOUR:     rd_byte = now.hour;
            REG_WEEK:     rd_byte = now.week;
            REG_DAY:      rd_byte = now.day;
            REG_MONTH:    rd_byte = now.month;
            REG_YEAR:     rd_byte = now.year;
            REG_ALM_MIN:  rd_byte = alm_min_ff;
            REG_ALM_HOUR: rd_byte = alm_hour_ff;
            REG_ALM_DAY:  rd_byte = alm_day_ff;
            REG_ALM_WEEK: rd_byte = alm_week_ff;
            REG_TMR:      rd_byte = tmr_reload_ff;
            REG_CTRL:     rd_byte = ctrl_ff;
            REG_FLAG:     rd_byte = BYTE_W'(flags_ff);
            default:      rd_byte = '0;
         endcase
      end
   end

   // User memory holds no reset so it can map to a plain RAM.
   always_ff @(posedge sys_clk) begin
      if (ce && wr_en && addr_ff[RAM_SEL_BIT]) begin
         ram_ff[addr_ff[RAM_AW-1:0]] <= in_byte; // [R12]
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         alm_min_ff    <= CFG_RESET;
         alm_hour_ff   <= CFG_RESET;
         alm_day_ff    <= CFG_RESET;
         alm_week_ff   <= CFG_RESET;
         tmr_reload_ff <= CFG_RESET;
         ctrl_ff       <= CFG_RESET;
      end else if (ce && wr_en) begin
         case (addr_ff)
            REG_ALM_MIN:  alm_min_ff    <= in_byte;
            REG_ALM_HOUR: alm_hour_ff   <= in_byte;
            REG_ALM_DAY:  alm_day_ff    <= in_byte;
            REG_ALM_WEEK: alm_week_ff   <= in_byte;
            REG_TMR:      tmr_reload_ff <= in_byte;
            REG_CTRL:     ctrl_ff       <= in_byte;
            default: ;
         endcase
      end
   end

   rtc_calendar u_calendar (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .ce          (ce),
      .sec_tick    (sec_tick_ff),
      .wr_en       (cal_we),
      .wr          (wr),
      .now         (now),
      .minute_tick (minute_tick)
   );
   // Interrupt events.
   assign tmr_load    = wr_en && (addr_ff == REG_TMR);
   assign alarm_match = (now.min == alm_min_ff) && (now.hour == alm_hour_ff)
                        && (now.day == alm_day_ff) && (now.week == alm_week_ff);
   assign alarm_set   = minute_tick && ctrl_ff[CTL_ALM_EN] && alarm_match; // [R9]
   assign upd_set     = ctrl_ff[CTL_UPD_EN]
                        && (ctrl_ff[CTL_UPD_MIN] ? minute_tick : sec_tick_ff); // [R10]
   assign tmr_set     = sec_tick_ff && ctrl_ff[CTL_TMR_EN] && !tmr_load
                        && (tmr_cnt_ff <= TMR_ONE);
   assign flag_set    = {tmr_set, upd_set, alarm_set};
   // Writing a zero clears a flag; a new event in the same cycle still wins.
   assign flag_clr    = (wr_en && addr_ff == REG_FLAG) ? ~in_byte[FLAG_W-1:0] : '0;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tmr_cnt_ff <= CFG_RESET;
      end else if (ce) begin
         if (tmr_load) begin
            tmr_cnt_ff <= in_byte;
         end else if (sec_tick_ff && ctrl_ff[CTL_TMR_EN]) begin
            tmr_cnt_ff <= (tmr_cnt_ff <= TMR_ONE) ? tmr_reload_ff : tmr_cnt_ff - 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flags_ff <= FLAG_RESET;
      end else if (ce) begin
         flags_ff <= (flags_ff & ~flag_clr) | flag_set; // [R14]
      end
   end
   // Open-drain pins: the level is low whenever the enable is set, the enable carries the state.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timer_irq_n_n_ff  <= 1'b1;
         timer_irq_n_oe_ff <= 1'b0;
         alarm_irq_n_n_ff  <= 1'b1;
         alarm_irq_n_oe_ff <= 1'b0;
      end else if (ce) begin
         timer_irq_n_n_ff  <= ~flags_ff[FLG_TMR]; // [R7]
         timer_irq_n_oe_ff <= flags_ff[FLG_TMR]; // [R7] [R14]
         alarm_irq_n_n_ff  <= ~(flags_ff[FLG_ALM] | flags_ff[FLG_UPD]); // [R8]
         alarm_irq_n_oe_ff <= flags_ff[FLG_ALM] | flags_ff[FLG_UPD]; // [R8] [R14]
      end
   end
   assign serial_data_out    = sdo_ff;
   assign serial_data_out_oe = sdo_oe_ff;
   assign refclk_out         = refclk_ff;
   assign refclk_out_oe      = refclk_oe_ff;
   assign timer_irq_n        = timer_irq_n_n_ff;
   assign timer_irq_n_oe     = timer_irq_n_oe_ff;
   assign alarm_irq_n        = alarm_irq_n_n_ff;
   assign alarm_irq_n_oe     = alarm_irq_n_oe_ff;
   chk_deselect_reset: assert property ( // [R1] [R15]
      @(posedge sys_clk) disable iff (rst)
      (ce && !sel) |=> (phase_ff == PH_CMD && bit_cnt_ff == FIRST_BIT))
      else $error("Deselect did not reset the shift logic");
   chk_dout_release: assert property ( // [R2]
      @(posedge sys_clk) disable iff (rst)
      (ce && !sel) |=> !serial_data_out_oe)
      else $error("Data output driven while deselected");
   chk_write_sample: assert property ( // [R3]
      @(posedge sys_clk) disable iff (rst)
      (ce && rise) |=> shift_ff[0] == $past(serial_data_in))
      else $error("Rising edge did not sample the data input");
   chk_read_edge: assert property ( // [R4]
      @(posedge sys_clk) disable iff (rst)
      $changed(serial_data_out) |-> $past(ce && fall && phase_ff == PH_RD))
      else $error("Read data changed outside a falling edge");
   chk_ref_enable: assert property ( // [R5]
      @(posedge sys_clk) disable iff (rst)
      ce |=> refclk_out_oe == $past(refclk_out_enable))
      else $error("Reference output enable does not follow its input");
   chk_ref_period: assert property ( // [R6]
      @(posedge sys_clk) disable iff (rst)
      (ce && nco_sum[NCO_W]) |-> (ref_gap_ff >= GAP_W'(REF_HALF_MIN - 1)
                                  && ref_gap_ff <= GAP_W'(REF_HALF_MAX - 1)))
      else $error("Reference half period out of range");
   chk_ref_alive: assert property ( // [R6]
      @(posedge sys_clk) disable iff (rst)
      ref_gap_ff <= GAP_W'(REF_HALF_MAX - 1))
      else $error("Reference clock stopped toggling");
   chk_timer_pin: assert property ( // [R7]
      @(posedge sys_clk) disable iff (rst)
      (ce && flags_ff[FLG_TMR]) |=> (timer_irq_n_oe && !timer_irq_n))
      else $error("Timer flag not pulling its pin low");
   chk_alarm_pin: assert property ( // [R8]
      @(posedge sys_clk) disable iff (rst)
      (ce && !flags_ff[FLG_ALM] && !flags_ff[FLG_UPD]) |=> !alarm_irq_n_oe)
      else $error("Alarm pin driven without alarm or update flag");
   chk_alarm_set: assert property ( // [R9]
      @(posedge sys_clk) disable iff (rst)
      (ce && minute_tick && ctrl_ff[CTL_ALM_EN] && alarm_match)
      |=> flags_ff[FLG_ALM] ##1 (!$past(ce) || alarm_irq_n_oe))
      else $error("Alarm match did not raise the alarm interrupt");
   chk_update_set: assert property ( // [R10]
      @(posedge sys_clk) disable iff (rst)
      (ce && ctrl_ff[CTL_UPD_EN] && !ctrl_ff[CTL_UPD_MIN] && sec_tick_ff)
      |=> flags_ff[FLG_UPD])
      else $error("Second update did not set its flag");
   chk_ram_write: assert property ( // [R12]
      @(posedge sys_clk) disable iff (rst)
      (ce && wr_en && addr_ff[RAM_SEL_BIT])
      |=> ram_ff[$past(addr_ff[RAM_AW-1:0])] == $past(in_byte))
      else $error("User memory write lost");
   chk_flag_hold: assert property ( // [R14]
      @(posedge sys_clk) disable iff (rst)
      (flags_ff[FLG_TMR] && !(ce && flag_clr[FLG_TMR])) |=> flags_ff[FLG_TMR])
      else $error("Timer flag dropped without a clear");
endmodule : rtc_serial_pin_interface

// [rtl/rtc_pkg.sv]
// Shared constants, types and register layout of the serial real-time clock.
package rtc_pkg;

   localparam int SYS_HZ       = 10_000_000;
   localparam int REF_HZ       = 32_768;
   localparam int NCO_W        = 32;
   localparam logic [NCO_W-1:0] NCO_INC =
      NCO_W'((64'(2 * REF_HZ) << NCO_W) / 64'(SYS_HZ));
   localparam int REF_HALF_MIN = SYS_HZ / (2 * REF_HZ);
   localparam int REF_HALF_MAX = REF_HALF_MIN + 1;
   localparam int GAP_W        = 8;

   localparam int BYTE_W       = 8;
   localparam int ADDR_W       = 5;
   localparam int RAM_DEPTH    = 16;
   localparam int RAM_AW       = 4;
   localparam int BIT_CNT_W    = 3;
   localparam int FLAG_W       = 3;
   localparam logic [BIT_CNT_W-1:0] FIRST_BIT = 3'h0;
   localparam logic [BIT_CNT_W-1:0] LAST_BIT  = 3'h7;
   localparam int CMD_RD_BIT   = 7;
   localparam int RAM_SEL_BIT  = 4;

   localparam logic [ADDR_W-1:0] REG_SEC      = 5'h00;
   localparam logic [ADDR_W-1:0] REG_MIN      = 5'h01;
   localparam logic [ADDR_W-1:0] REG_HOUR     = 5'h02;
   localparam logic [ADDR_W-1:0] REG_WEEK     = 5'h03;
   localparam logic [ADDR_W-1:0] REG_DAY      = 5'h04;
   localparam logic [ADDR_W-1:0] REG_MONTH    = 5'h05;
   localparam logic [ADDR_W-1:0] REG_YEAR     = 5'h06;
   localparam logic [ADDR_W-1:0] REG_ALM_MIN  = 5'h07;
   localparam logic [ADDR_W-1:0] REG_ALM_HOUR = 5'h08;
   localparam logic [ADDR_W-1:0] REG_ALM_DAY  = 5'h09;
   localparam logic [ADDR_W-1:0] REG_ALM_WEEK = 5'h0a;
   localparam logic [ADDR_W-1:0] REG_TMR      = 5'h0b;
   localparam logic [ADDR_W-1:0] REG_CTRL     = 5'h0c;
   localparam logic [ADDR_W-1:0] REG_FLAG     = 5'h0d;

   localparam int CTL_UPD_MIN  = 0;
   localparam int CTL_ALM_EN   = 1;
   localparam int CTL_UPD_EN   = 2;
   localparam int CTL_TMR_EN   = 3;
   localparam int FLG_ALM      = 0;
   localparam int FLG_UPD      = 1;
   localparam int FLG_TMR      = 2;
   localparam logic [BYTE_W-1:0] CFG_RESET = 8'h00;
   localparam logic [FLAG_W-1:0] FLAG_RESET = 3'h0;
   localparam logic [BYTE_W-1:0] TMR_ONE   = 8'h01;

   localparam logic [BYTE_W-1:0] SEC_MAX   = 8'h3b;
   localparam logic [BYTE_W-1:0] MIN_MAX   = 8'h3b;
   localparam logic [BYTE_W-1:0] HOUR_MAX  = 8'h17;
   localparam logic [BYTE_W-1:0] WEEK_MAX  = 8'h06;
   localparam logic [BYTE_W-1:0] MONTH_MAX = 8'h0c;
   localparam logic [BYTE_W-1:0] YEAR_MAX  = 8'h63;
   localparam logic [BYTE_W-1:0] FIRST_DAY = 8'h01;
   localparam logic [BYTE_W-1:0] ZERO_B    = 8'h00;
   localparam logic [BYTE_W-1:0] MON_FEB   = 8'h02;
   localparam logic [BYTE_W-1:0] MON_MAR   = 8'h03;
   localparam logic [BYTE_W-1:0] MON_APR   = 8'h04;
   localparam logic [BYTE_W-1:0] MON_JUN   = 8'h06;
   localparam logic [BYTE_W-1:0] MON_SEP   = 8'h09;
   localparam logic [BYTE_W-1:0] MON_NOV   = 8'h0b;
   localparam logic [BYTE_W-1:0] DAYS_28   = 8'h1c;
   localparam logic [BYTE_W-1:0] DAYS_29   = 8'h1d;
   localparam logic [BYTE_W-1:0] DAYS_30   = 8'h1e;
   localparam logic [BYTE_W-1:0] DAYS_31   = 8'h1f;

   typedef struct packed {
      logic [BYTE_W-1:0] sec;
      logic [BYTE_W-1:0] min;
      logic [BYTE_W-1:0] hour;
      logic [BYTE_W-1:0] week;
      logic [BYTE_W-1:0] day;
      logic [BYTE_W-1:0] month;
      logic [BYTE_W-1:0] year;
   } cal_time_type;

   localparam cal_time_type CAL_RESET = '{sec: 8'h00, min: 8'h00, hour: 8'h00,
      week: 8'h00, day: 8'h01, month: 8'h01, year: 8'h00};

   typedef struct packed {
      logic [ADDR_W-1:0] idx;
      logic [BYTE_W-1:0] data;
   } reg_write_type;

   typedef enum logic [1:0] {
      PH_CMD = 2'b00,
      PH_WR  = 2'b01,
      PH_RD  = 2'b10
   } phase_type;

endpackage : rtc_pkg

// [rtl/rtc_calendar.sv]
// Time and calendar counters with leap-year handling for years 2000 to 2099.
`timescale 1ns/10ps
module rtc_calendar (
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   ce,
   input  wire logic                   sec_tick,
   input  wire logic                   wr_en,
   input  wire rtc_pkg::reg_write_type wr,
   output      rtc_pkg::cal_time_type  now,
   output      logic                   minute_tick
);
   import rtc_pkg::*;

   cal_time_type now_ff;
   logic         minute_tick_ff;

   // Every year divisible by four is a leap year inside the supported century.
   function automatic logic [BYTE_W-1:0] month_len(input logic [BYTE_W-1:0] month,
                                                    input logic [BYTE_W-1:0] year);
      case (month)
         MON_FEB: month_len = (year[1:0] == 2'h0) ? DAYS_29 : DAYS_28; // [R11]
         MON_APR, MON_JUN, MON_SEP, MON_NOV: month_len = DAYS_30;
         default: month_len = DAYS_31;
      endcase
   endfunction : month_len

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         now_ff         <= CAL_RESET;
         minute_tick_ff <= 1'b0;
      end else if (ce) begin
         minute_tick_ff <= 1'b0;
         if (wr_en) begin
            // A host write replaces the field and swallows a coinciding tick.
            case (wr.idx)
               REG_SEC:   now_ff.sec   <= wr.data;
               REG_MIN:   now_ff.min   <= wr.data;
               REG_HOUR:  now_ff.hour  <= wr.data;
               REG_WEEK:  now_ff.week  <= wr.data;
               REG_DAY:   now_ff.day   <= wr.data;
               REG_MONTH: now_ff.month <= wr.data;
               REG_YEAR:  now_ff.year  <= wr.data;
               default: ;
            endcase
         end else if (sec_tick) begin
            if (now_ff.sec < SEC_MAX) begin
               now_ff.sec <= now_ff.sec + 8'h01;
            end else begin
               now_ff.sec     <= ZERO_B;
               minute_tick_ff <= 1'b1;
               if (now_ff.min < MIN_MAX) begin
                  now_ff.min <= now_ff.min + 8'h01;
               end else begin
                  now_ff.min <= ZERO_B;
                  if (now_ff.hour < HOUR_MAX) begin
                     now_ff.hour <= now_ff.hour + 8'h01;
                  end else begin
                     now_ff.hour <= ZERO_B;
                     now_ff.week <= (now_ff.week < WEEK_MAX) ? now_ff.week + 8'h01 : ZERO_B;
                     if (now_ff.day < month_len(now_ff.month, now_ff.year)) begin // [R11]
                        now_ff.day <= now_ff.day + 8'h01;
                     end else begin
                        now_ff.day <= FIRST_DAY;
                        if (now_ff.month < MONTH_MAX) begin
                           now_ff.month <= now_ff.month + 8'h01;
                        end else begin
                           now_ff.month <= FIRST_DAY;
                           now_ff.year  <= (now_ff.year < YEAR_MAX) ? now_ff.year + 8'h01 : ZERO_B;
                        end
                     end
                  end
               end
            end
         end
      end
   end

   assign now         = now_ff;
   assign minute_tick = minute_tick_ff;

   chk_leap_day: assert property ( // [R11]
      @(posedge sys_clk) disable iff (rst)
      (ce && sec_tick && !wr_en && now_ff.month == MON_FEB && now_ff.day == DAYS_28
       && now_ff.hour == HOUR_MAX && now_ff.min == MIN_MAX && now_ff.sec == SEC_MAX)
      |=> (now_ff.year[1:0] == 2'h0) ? (now_ff.day == DAYS_29) : (now_ff.month == MON_MAR))
      else $error("February end of month handled wrongly");

endmodule : rtc_calendar

// [tb/rtc_host_model.sv]
// Host model that selects the clock chip and shifts bytes MSB first.
`timescale 1ns/10ps
module rtc_host_model (
   input  wire logic sys_clk,
   input  wire logic serial_data_out,
   input  wire logic serial_data_out_oe,
   output      logic chip_enable_a,
   output      logic chip_enable_b,
   output      logic serial_clk,
   output      logic serial_data_in
);
   initial begin
      chip_enable_a  = 1'b0;
      chip_enable_b  = 1'b0;
      serial_clk     = 1'b0;
      serial_data_in = 1'b0;
   end
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step
   // A released data line flips so that stale values never look valid.
   task automatic sel(input logic a, input logic b);
      step(1);
      if (!(a && b)) serial_data_in = ~serial_data_in;
      chip_enable_a = a;
      chip_enable_b = b;
      step(2);
   endtask : sel
   task automatic xfer(input logic [7:0] w, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         serial_clk     = 1'b0;
         serial_data_in = w[i];
         step(3);
         // An undriven data line reads as the inverse, so stale bits cannot pass.
         r[i]       = serial_data_out_oe ? serial_data_out : ~serial_data_out;
         serial_clk = 1'b1;
         step(3);
      end
      serial_clk = 1'b0;
      step(3);
   endtask : xfer
endmodule : rtc_host_model

// [tb/rtc_serial_pin_interface_bench.sv]
// Self-checking bench for the serial real-time clock pins.
`timescale 1ns/10ps
module rtc_serial_pin_interface_bench;
   logic sys_clk, rst, fen, en, cea, ceb, sck, sdi;
   logic sdo, sdo_oe, ref_o, ref_oe, tq, tq_oe, aq, aq_oe;
   logic [7:0] rd;
   int         errors = 0;
   int         cmp_count = 0;
   int         n;
   rtc_host_model host (.sys_clk(sys_clk), .serial_data_out(sdo), .serial_data_out_oe(sdo_oe),
      .chip_enable_a(cea), .chip_enable_b(ceb), .serial_clk(sck), .serial_data_in(sdi));
   rtc_serial_pin_interface #(.SEC_CYCLES(20)) dut (.sys_clk(sys_clk), .rst(rst), .ce(en),
      .chip_enable_a(cea), .chip_enable_b(ceb), .serial_clk(sck), .serial_data_in(sdi),
      .serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .refclk_out_enable(fen),
      .refclk_out(ref_o), .refclk_out_oe(ref_oe), .timer_irq_n(tq), .timer_irq_n_oe(tq_oe),
      .alarm_irq_n(aq), .alarm_irq_n_oe(aq_oe));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
      host.sel(1'b1, 1'b1);
      host.xfer(a, rd);
      host.xfer(d0, rd);
      host.xfer(d1, rd);
      chk({7'h0, sdo_oe}, 8'h00);
      host.sel(1'b0, 1'b0);
   endtask : wr
   task automatic rd2(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
      host.sel(1'b1, 1'b1);
      host.xfer(8'h80 | a, rd);
      host.xfer(8'h00, rd);
      chk(rd, e0);
      host.xfer(8'h00, rd);
      chk(rd, e1);
      host.sel(1'b0, 1'b0);
      host.step(3);
      chk({7'h0, sdo_oe}, 8'h00);
   endtask : rd2
   task automatic t_ram();
      chk({2'b00, tq, aq, tq_oe, aq_oe, sdo_oe, ref_oe}, 8'h30);
      wr(8'h10, 8'ha5, 8'h5a);
      host.sel(1'b1, 1'b0);
      host.xfer(8'h10, rd);
      host.xfer(8'h3c, rd);
      host.sel(1'b0, 1'b1);
      host.xfer(8'h90, rd);
      host.xfer(8'h00, rd);
      chk({7'h0, sdo_oe}, 8'h00);
      host.sel(1'b1, 1'b1);
      host.xfer(8'h11, rd);
      host.sel(1'b0, 1'b0);
      rd2(8'h10, 8'ha5, 8'h5a);
   endtask : t_ram
   task automatic t_ref();
      host.step(3);
      chk({7'h0, ref_oe}, 8'h00);
      fen = 1'b1;
      host.step(3);
      chk({7'h0, ref_oe}, 8'h01);
      n = 0;
      rd[0] = ref_o;
      repeat (1000) begin
         host.step(1);
         if (ref_o !== rd[0]) n++;
         rd[0] = ref_o;
      end
      // 100 us at 32.768 kHz holds 6.55 half periods.
      chk(8'(n >= 6 && n <= 7), 8'h01);
      // With the clock enable low the reference must hold past a half period.
      en    = 1'b0;
      n     = 0;
      rd[0] = ref_o;
      repeat (200) begin
         host.step(1);
         if (ref_o !== rd[0]) n++;
      end
      chk(8'(n), 8'h00);
      en = 1'b1;
   endtask : t_ref
   task automatic t_irq(input logic [7:0] cfg, input logic tmr);
      wr(8'h0b, 8'h01, cfg);
      for (n = 0; n < 1500 && !(tq_oe === tmr && aq_oe === !tmr); n++) host.step(1);
      chk({tq_oe, tq, aq_oe, aq}, tmr ? 8'h09 : 8'h06);
      wr(8'h0c, 8'h00, 8'h00);
      host.step(3);
      chk({tq_oe, aq_oe}, 8'h00);
   endtask : t_irq
   // The minute rollover about a minute after the time write must hit the alarm.
   task automatic t_alarm();
      wr(8'h07, 8'h01, 8'h00);
      wr(8'h09, 8'h01, 8'h00);
      wr(8'h00, 8'h00, 8'h00);
      t_irq(8'h02, 1'b0);
   endtask : t_alarm
   // Year 0 is a leap year, so the end of 28 February rolls into the 29th.
   task automatic t_leap();
      wr(8'h02, 8'h17, 8'h00);
      wr(8'h04, 8'h1c, 8'h02);
      wr(8'h00, 8'h37, 8'h3b);
      host.step(100);
      rd2(8'h04, 8'h1d, 8'h02);
   endtask : t_leap
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      #5_000_000;
      errors++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      fen = 1'b0;
      en  = 1'b1;
      repeat (12) @(posedge sys_clk);
      #1 rst = 1'b0;
      t_ram();
      t_ref();
      t_irq(8'h08, 1'b1);
      t_irq(8'h04, 1'b0);
      t_alarm();
      t_leap();
      summarize();
   end
endmodule : rtc_serial_pin_interface_bench
